// ### pcelc_defs.vh
// constants for the pcie capability, error and link configuration block
`ifndef PCELC_DEFS_VH
`define PCELC_DEFS_VH

// configuration space byte offsets
`define PCELC_LNKCAP_OFS      12'h08c
`define PCELC_LNKCTLSTS_OFS   12'h090
`define PCELC_DEVCAP2_OFS     12'h0a4
`define PCELC_DEVCTL2_OFS     12'h0a8
`define PCELC_AER_HDR_OFS     12'h100
`define PCELC_AER_CAPCTL_OFS  12'h118

// device capabilities 2 / device control 2 fields
`define PCELC_CTO_LSB         0
`define PCELC_CTO_W           4
`define PCELC_CTO_DIS_BIT     4
`define PCELC_DEVCTL2_RST     16'h0000

// completion timeout range codes
`define PCELC_CTO_NONE        4'h0
`define PCELC_CTO_A           4'h1
`define PCELC_CTO_B           4'h2
`define PCELC_CTO_AB          4'h3
`define PCELC_CTO_BC          4'h6
`define PCELC_CTO_BCD         4'he
`define PCELC_CTO_ABCD        4'hf

// link capabilities and link status fields
`define PCELC_PORTNUM_LSB     24
`define PCELC_PORTNUM_RP      8'h01
`define PCELC_SDN_BIT         19
`define PCELC_DLLA_BIT        20
`define PCELC_SLOTCLK_BIT     28

// advanced error reporting
`define PCELC_AER_HDR_VAL     32'h00020001
`define PCELC_ECRC_GEN_BIT    5
`define PCELC_ECRC_CHK_BIT    7

// tlp header dword 0 digest flag
`define PCELC_TD_BIT          15

// completion buffer
`define PCELC_CPLBUF_DEPTH    256

// timeout ranges in microseconds, clock rate in MHz and limits in cycles
`define PCELC_CLK_MHZ         250
`define PCELC_RANGE_A_MIN_US  50
`define PCELC_RANGE_A_MAX_US  10000
`define PCELC_RANGE_B_MAX_US  250000
`define PCELC_RANGE_C_MAX_US  4000000
`define PCELC_RANGE_D_MAX_US  64000000
`define PCELC_CTO_DEF_MAX_US  50000
`define PCELC_CTO_REC_MIN_US  10000
`define PCELC_CTO_DEF_MAX_CYC (`PCELC_CTO_DEF_MAX_US * `PCELC_CLK_MHZ)
`define PCELC_CTO_REC_MIN_CYC (`PCELC_CTO_REC_MIN_US * `PCELC_CLK_MHZ)

`endif

// ### pcelc_rx_digest.v
// receive tlp path: keeps or strips the trailing digest dword
`timescale 1ns/1ps
`default_nettype none
`include "pcelc_defs.vh"

module pcelc_rx_digest (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // mode
  input  wire        fwd_en,
  // from link side
  input  wire        in_valid,
  input  wire        in_sop,
  input  wire        in_eop,
  input  wire [31:0] in_data,
  // to application
  output reg         out_valid,
  output reg         out_sop,
  output reg         out_eop,
  output reg  [31:0] out_data
);

  reg        td_q;
  reg        held_v_q;
  reg        held_sop_q;
  reg [31:0] held_data_q;
  wire       td_now;
  wire       strip;

  assign td_now = in_sop ? in_data[`PCELC_TD_BIT] : td_q;
  // only tlps that carry a digest are held back one dword
  assign strip  = !fwd_en && td_now;

  always @(posedge mclk) begin
    if (!rst_n) begin
      td_q        <= 1'b0;
      held_v_q    <= 1'b0;
      held_sop_q  <= 1'b0;
      held_data_q <= 32'h00000000;
      out_valid   <= 1'b0;
      out_sop     <= 1'b0;
      out_eop     <= 1'b0;
      out_data    <= 32'h00000000;
    end else begin
      out_valid <= 1'b0;
      if (in_valid) begin
        if (in_sop)
          td_q <= in_data[`PCELC_TD_BIT];
        if (!strip) begin
          out_valid <= 1'b1;
          out_sop   <= in_sop;
          out_eop   <= in_eop;
          out_data  <= in_data;
        end else begin
          if (held_v_q) begin
            out_valid <= 1'b1;
            out_sop   <= held_sop_q;
            out_eop   <= in_eop;
            out_data  <= held_data_q;
            // digest dropped, so td must no longer claim one
            if (held_sop_q)
              out_data[`PCELC_TD_BIT] <= 1'b0;
          end
          held_v_q    <= !in_eop;
          held_sop_q  <= in_sop;
          held_data_q <= in_data;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### pcelc_top.v
// capability, error reporting and link configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "pcelc_defs.vh"

module pcelc_top #(
  parameter       IS_ROOT_PORT   = 0,
  parameter       ISSUES_REQ     = 1,
  parameter [3:0] CTO_RANGES     = `PCELC_CTO_ABCD,
  parameter       CTO_DIS_EN     = 1,
  parameter       AER_EN         = 0,
  parameter       ECRC_CHK_EN    = 0,
  parameter       ECRC_GEN_EN    = 0,
  parameter       ECRC_FWD_EN    = 0,
  parameter       TRACK_CPLBUF   = 0,
  parameter [7:0] PORT_NUM       = `PCELC_PORTNUM_RP,
  parameter       DLL_ACT_EN     = 0,
  parameter       HOT_PLUG_CAP   = 0,
  parameter       SURPRISE_DN_EN = 0,
  parameter       SLOT_CLK_EN    = 0,
  parameter       CPLBUF_DEPTH   = `PCELC_CPLBUF_DEPTH
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // configuration space access
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [11:0] cfg_addr,
  input  wire [31:0] cfg_wdata,
  input  wire [3:0]  cfg_be,
  output reg  [31:0] cfg_rdata,
  output reg         cfg_rvalid,
  // completion timeout controls to the application timer
  output reg  [3:0]  cto_value,
  output reg         cto_disable,
  // receive completion buffer accounting
  input  wire        cplbuf_push,
  input  wire        cplbuf_pop,
  output reg         cplbuf_overflow,
  // receive tlp stream, link side
  input  wire        rx_in_valid,
  input  wire        rx_in_sop,
  input  wire        rx_in_eop,
  input  wire [31:0] rx_in_data,
  // receive tlp stream, application side
  output wire        rx_out_valid,
  output wire        rx_out_sop,
  output wire        rx_out_eop,
  output wire [31:0] rx_out_data
);

  localparam CNT_W = $clog2(CPLBUF_DEPTH + 1);
  localparam [CNT_W-1:0] CNT_FULL = CPLBUF_DEPTH[CNT_W-1:0];

  // reserved or unknown range codes collapse to none
  function [3:0] legal_ranges;
    input [3:0] code;
    begin
      case (code)
        `PCELC_CTO_A, `PCELC_CTO_B, `PCELC_CTO_AB,
        `PCELC_CTO_BC, `PCELC_CTO_BCD, `PCELC_CTO_ABCD:
          legal_ranges = code;
        default:
          legal_ranges = `PCELC_CTO_NONE;
      endcase
    end
  endfunction

  // fixed capability values, built from parameters only
  wire        req_fn     = (IS_ROOT_PORT != 0) || (ISSUES_REQ != 0);
  wire [3:0]  ranges     = req_fn ? legal_ranges(CTO_RANGES) : `PCELC_CTO_NONE;
  wire        prog_ok    = (ranges != `PCELC_CTO_NONE);
  wire        dis_ok     = req_fn && (CTO_DIS_EN != 0);
  wire        aer_on     = (AER_EN != 0);
  wire        chk_cap    = aer_on && (ECRC_CHK_EN != 0);
  wire        gen_cap    = aer_on && (ECRC_GEN_EN != 0);
  wire [7:0]  port_num   = (IS_ROOT_PORT != 0) ? PORT_NUM : 8'h00;
  wire        dlla_cap   = (DLL_ACT_EN != 0) || (HOT_PLUG_CAP != 0);
  wire        sdn_cap    = (SURPRISE_DN_EN != 0);
  wire        slot_clk   = (SLOT_CLK_EN != 0);
  wire        fwd_en     = aer_on && (ECRC_FWD_EN != 0);

  reg  [15:0] devctl2_q;
  reg  [CNT_W-1:0] cpl_cnt_q;
  reg  [31:0] rdata_d;

  wire wr_ctl2 = cfg_wr && (cfg_addr == `PCELC_DEVCTL2_OFS);

  // device control 2: only supported controls are writable
  always @(posedge mclk) begin
    if (!rst_n) begin
      devctl2_q <= `PCELC_DEVCTL2_RST;
    end else if (wr_ctl2) begin
      if (cfg_be[0] && prog_ok)
        devctl2_q[`PCELC_CTO_LSB +: `PCELC_CTO_W] <= cfg_wdata[`PCELC_CTO_LSB +: `PCELC_CTO_W];
      if (cfg_be[0] && dis_ok)
        devctl2_q[`PCELC_CTO_DIS_BIT] <= cfg_wdata[`PCELC_CTO_DIS_BIT];
    end
  end

  // controls go out to the application, which owns the timer itself
  always @(posedge mclk) begin
    if (!rst_n) begin
      cto_value   <= `PCELC_CTO_NONE;
      cto_disable <= 1'b0;
    end else begin
      cto_value   <= devctl2_q[`PCELC_CTO_LSB +: `PCELC_CTO_W];
      cto_disable <= devctl2_q[`PCELC_CTO_DIS_BIT];
    end
  end

  // read mux; unmapped and absent capabilities read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (cfg_addr)
      `PCELC_DEVCAP2_OFS: begin
        rdata_d[`PCELC_CTO_LSB +: `PCELC_CTO_W] = ranges;
        rdata_d[`PCELC_CTO_DIS_BIT]             = dis_ok;
      end
      `PCELC_DEVCTL2_OFS:
        rdata_d[15:0] = devctl2_q;
      `PCELC_LNKCAP_OFS: begin
        rdata_d[`PCELC_PORTNUM_LSB +: 8] = port_num;
        rdata_d[`PCELC_DLLA_BIT]         = dlla_cap;
        rdata_d[`PCELC_SDN_BIT]          = sdn_cap;
      end
      `PCELC_LNKCTLSTS_OFS:
        rdata_d[`PCELC_SLOTCLK_BIT] = slot_clk;
      `PCELC_AER_HDR_OFS:
        rdata_d = aer_on ? `PCELC_AER_HDR_VAL : 32'h00000000;
      `PCELC_AER_CAPCTL_OFS: begin
        rdata_d[`PCELC_ECRC_CHK_BIT] = chk_cap;
        rdata_d[`PCELC_ECRC_GEN_BIT] = gen_cap;
      end
      default:
        rdata_d = 32'h00000000;
    endcase
  end

  // read data registered; fixed fields come from parameters, not storage
  always @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rdata  <= 32'h00000000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= rdata_d;
    end
  end

  // completion buffer occupancy; overflow sticks until reset
  always @(posedge mclk) begin
    if (!rst_n) begin
      cpl_cnt_q       <= {CNT_W{1'b0}};
      cplbuf_overflow <= 1'b0;
    end else if (TRACK_CPLBUF != 0) begin
      if (cplbuf_push && !cplbuf_pop && (cpl_cnt_q == CNT_FULL))
        cplbuf_overflow <= 1'b1;
      else if (cplbuf_push && !cplbuf_pop)
        cpl_cnt_q <= cpl_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      else if (!cplbuf_push && cplbuf_pop && (cpl_cnt_q != {CNT_W{1'b0}}))
        cpl_cnt_q <= cpl_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  pcelc_rx_digest u_rx_digest (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .fwd_en    (fwd_en),
    .in_valid  (rx_in_valid),
    .in_sop    (rx_in_sop),
    .in_eop    (rx_in_eop),
    .in_data   (rx_in_data),
    .out_valid (rx_out_valid),
    .out_sop   (rx_out_sop),
    .out_eop   (rx_out_eop),
    .out_data  (rx_out_data)
  );

endmodule
`default_nettype wire

// ### pcelc_top_properties.sv
// assertion checker for the capability, error and link configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcelc_top_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // configuration access
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire logic [3:0]  cto_value,
  input wire logic        cto_disable,
  // buffer and stream
  input wire logic        cplbuf_push,
  input wire logic        cplbuf_pop,
  input wire logic        cplbuf_overflow,
  input wire logic        rx_in_valid,
  input wire logic        rx_out_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a lone control write, not overtaken by another one
  sequence s_dc2_wr;
    cfg_wr && cfg_addr == 12'h0a8 && cfg_be[0] ##1 !cfg_wr;
  endsequence
  sequence s_quiet;
    !cfg_wr ##1 !cfg_wr;
  endsequence
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
    else $error("read data moved");
  a_value_follows: assert property (s_dc2_wr |=> cto_value == $past(cfg_wdata[3:0], 2))
    else $error("timeout value not taken");
  a_disable_follows: assert property (s_dc2_wr |=> cto_disable == $past(cfg_wdata[4], 2))
    else $error("timeout disable not taken");
  a_ctl_steady: assert property (s_quiet |=> $stable(cto_value) && $stable(cto_disable))
    else $error("control moved without write");
  a_ovf_sticky: assert property (cplbuf_overflow |=> cplbuf_overflow)
    else $error("overflow flag dropped");
  a_ovf_cause: assert property ($rose(cplbuf_overflow) |-> $past(cplbuf_push && !cplbuf_pop))
    else $error("overflow without push");
  a_rx_out_cause: assert property (rx_out_valid |-> $past(rx_in_valid))
    else $error("beat out without beat in");
endmodule
bind pcelc_top pcelc_top_properties u_props (.mclk(mclk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .cto_value(cto_value), .cto_disable(cto_disable), .cplbuf_push(cplbuf_push), .cplbuf_pop(cplbuf_pop),
  .cplbuf_overflow(cplbuf_overflow), .rx_in_valid(rx_in_valid), .rx_out_valid(rx_out_valid));
`default_nettype wire

// ### pcelc_app_model.sv
// application-side model: captures delivered tlp beats, runs the timeout timer
`timescale 1ns/1ps
`default_nettype none
module pcelc_app_model (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // delivered tlp stream
  input wire logic        rx_valid,
  input wire logic        rx_sop,
  input wire logic        rx_eop,
  input wire logic [31:0] rx_data,
  // timeout control
  input wire logic        cto_disable
);
  logic [33:0] mem [8];
  logic [2:0]  cnt;
  logic [31:0] tmo_q;
  always @(posedge mclk) begin
    if (!rst_n) cnt <= 3'h0;
    else if (rx_valid) begin
      mem[cnt] <= {rx_sop, rx_eop, rx_data};
      cnt      <= cnt + 3'h1;
    end
  end
  // no backpressure exists, so every beat must be taken
  always @(posedge mclk) begin
    if (!rst_n || cto_disable) tmo_q <= 32'h0;
    else tmo_q <= tmo_q + 32'h1;
  end
endmodule
`default_nettype wire

// ### pcie_capability_error_link_config_tb_top.sv
// testbench for the capability, error and link configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "pcelc_defs.vh"
module pcie_capability_error_link_config_tb_top;
  logic        mclk, rst_n, cfg_rd, cfg_wr, push, pop, iv, is, ie, rvld, ovf, cdis, ov, os, oe;
  logic [31:0] cfg_wdata, cfg_rdata, id, od, d;
  logic        rvld2, ovf2, cdis2;
  logic [31:0] rdata2, d2;
  logic [3:0]  cval2;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be, cval;
  int          err_count, n_tests, i;
  logic [11:0] ra [6] = '{12'h08c, 12'h090, 12'h0a4, 12'h100, 12'h118, 12'h200};
  logic [31:0] rv [6] = '{32'h01100000, 32'h0, 32'h1f, `PCELC_AER_HDR_VAL, 32'h80, 32'h0};
  // default build: non-root requester, no aer, all link options off
  logic [31:0] rw [6] = '{32'h0, 32'h0, 32'h1f, 32'h0, 32'h0, 32'h0};
  logic [33:0] xp [6] = '{{2'b10, 32'h1}, {2'b00, 32'h11}, {2'b01, 32'h22},
                          {2'b10, 32'h3}, {2'b00, 32'h33}, {2'b01, 32'h44}};
  pcelc_top #(.IS_ROOT_PORT(1), .AER_EN(1), .ECRC_CHK_EN(1), .TRACK_CPLBUF(1), .HOT_PLUG_CAP(1)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rvalid(rvld), .cto_value(cval), .cto_disable(cdis),
    .cplbuf_push(push), .cplbuf_pop(pop), .cplbuf_overflow(ovf), .rx_in_valid(iv), .rx_in_sop(is),
    .rx_in_eop(ie), .rx_in_data(id), .rx_out_valid(ov), .rx_out_sop(os), .rx_out_eop(oe), .rx_out_data(od));
  pcelc_app_model u_app (.mclk(mclk), .rst_n(rst_n), .rx_valid(ov), .rx_sop(os), .rx_eop(oe), .rx_data(od),
    .cto_disable(cdis));
  // second build left at its defaults, so the off side of the root port, aer, ecrc check, buffer tracking and hot plug options is seen too
  pcelc_top u_dflt (
    .mclk(mclk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_be(cfg_be), .cfg_rdata(rdata2), .cfg_rvalid(rvld2), .cto_value(cval2), .cto_disable(cdis2),
    .cplbuf_push(push), .cplbuf_pop(pop), .cplbuf_overflow(ovf2), .rx_in_valid(iv), .rx_in_sop(is),
    .rx_in_eop(ie), .rx_in_data(id), .rx_out_valid(), .rx_out_sop(), .rx_out_eop(), .rx_out_data());
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 1'b0;
    #1;
    chk(rvld, 1, "read strobe");
    chk(rvld2, 1, "default read strobe");
    d  = cfg_rdata;
    d2 = rdata2;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
    @(posedge mclk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= v;
    cfg_be    <= b;
    @(posedge mclk);
    cfg_wr <= 1'b0;
  endtask
  task automatic beat(input logic s, input logic e, input logic [31:0] v);
    @(posedge mclk);
    iv <= 1'b1;
    is <= s;
    ie <= e;
    id <= v;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {cfg_rd, cfg_wr, push, pop, iv, is, ie, rst_n} = '0;
    cfg_addr  = '0;
    cfg_wdata = '0;
    cfg_be    = '0;
    id        = '0;
    err_count = 0;
    n_tests   = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h0a8);
    chk(d, 0, "control reset");
    for (i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(d, rv[i], "capability");
      chk(d2, rw[i], "default capability");
      wr(ra[i], 32'hffffffff, 4'hf);
      rd(ra[i]);
      chk(d, rv[i], "capability after write");
      chk(d2, rw[i], "default capability after write");
    end
    wr(12'h0a8, 32'hffffffff, 4'he);
    rd(12'h0a8);
    chk(d, 0, "control without enable");
    wr(12'h0a8, 32'hffffffff, 4'h1);
    rd(12'h0a8);
    chk(d, 32'h1f, "control all set");
    chk({cdis, cval}, 5'h1f, "timeout outputs");
    chk({cdis2, cval2}, 5'h1f, "default timeout outputs");
    chk(u_app.tmo_q, 0, "timer held while disabled");
    wr(12'h0a8, 32'h6, 4'h1);
    rd(12'h0a8);
    chk(d, 32'h6, "control range only");
    chk({cdis, cval}, 5'h06, "timeout outputs cleared");
    chk({cdis2, cval2}, 5'h06, "default timeout outputs cleared");
    // default depth of pushes fills the buffer, then a push with pop, then one too many
    @(posedge mclk);
    push <= 1'b1;
    repeat (`PCELC_CPLBUF_DEPTH) @(posedge mclk);
    pop <= 1'b1;
    @(posedge mclk);
    pop <= 1'b0;
    #1;
    chk(ovf, 0, "overflow while full");
    @(posedge mclk);
    push <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk(ovf, 1, "overflow flag");
    chk(ovf2, 0, "overflow untracked");
    beat(1'b1, 1'b0, 32'h00008001);
    beat(1'b0, 1'b0, 32'h11);
    beat(1'b0, 1'b0, 32'h22);
    beat(1'b0, 1'b1, 32'hdddddddd);
    beat(1'b1, 1'b0, 32'h00000003);
    beat(1'b0, 1'b0, 32'h33);
    beat(1'b0, 1'b1, 32'h44);
    @(posedge mclk);
    iv <= 1'b0;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 6; i++) chk(u_app.mem[i], xp[i], "delivered beat");
    chk(u_app.cnt, 6, "delivered count");
    final_report;
  end
endmodule
`default_nettype wire
